// >>> hw/lrm_params.svh
// Constants of the local reset and interrupt routing block
`ifndef LRM_PARAMS_SVH
`define LRM_PARAMS_SVH
`define LRM_NUM_CORES 2
`define LRM_SEL_WIDTH 4
`define LRM_SEL_ALL_BIT 3
`define LRM_SEL_CORE0 4'h0
`define LRM_SEL_CORE1 4'h1
`define LRM_CLK_PERIOD_NS 10
`define LRM_STROBE_MIN_PERIODS 12
`define LRM_HOST_HIGH_PERIODS 24
`define LRM_HOST_LOW_PERIODS 24
`define LRM_HOST_HIGH_CYCLES (`LRM_HOST_HIGH_PERIODS * `LRM_CLK_PERIOD_NS / `LRM_CLK_PERIOD_NS)
`define LRM_HOST_LOW_CYCLES (`LRM_HOST_LOW_PERIODS * `LRM_CLK_PERIOD_NS / `LRM_CLK_PERIOD_NS)
`define LRM_HOST_CNT_WIDTH 5
`define LRM_SYNC_STAGES 2
`endif

// >>> hw/lrm_pkg.sv
// Types of the local reset and interrupt routing block
package lrm_pkg;
    typedef enum logic [2:0] {
        LRM_HOST_IDLE = 3'b001,
        LRM_HOST_HIGH = 3'b010,
        LRM_HOST_LOW = 3'b100
    } lrm_host_state_t;
    typedef enum logic [2:0] {
        LRM_PIN_RESET = 3'b001,
        LRM_PIN_RELEASE = 3'b010,
        LRM_PIN_IRQ = 3'b100
    } lrm_pin_action_t;
endpackage : lrm_pkg

// >>> hw/lrm_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module lrm_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Data
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage1_reg <= RESET_VALUE;
            syncOut <= RESET_VALUE;
        end else begin
            stage1_reg <= asyncIn;
            syncOut <= stage1_reg;
        end
    end
endmodule : lrm_sync

// >>> hw/lrm_host_pulse.sv
// Host event pulse generator with minimum high and low widths
`timescale 1ns/1ps
`include "lrm_params.svh"
module lrm_host_pulse (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Request from the cores
    input wire logic eventReq,
    // Output pin and status
    output logic hostEventOut,
    output logic eventTaken
);
    localparam logic [`LRM_HOST_CNT_WIDTH-1:0] HighLast =
        `LRM_HOST_CNT_WIDTH'(`LRM_HOST_HIGH_CYCLES - 1);
    localparam logic [`LRM_HOST_CNT_WIDTH-1:0] LowLast =
        `LRM_HOST_CNT_WIDTH'(`LRM_HOST_LOW_CYCLES - 1);

    lrm_pkg::lrm_host_state_t state_reg;
    logic [`LRM_HOST_CNT_WIDTH-1:0] count_reg;

    // High for 24 periods, then low for at least 25 (24 in LOW, one in IDLE) before another pulse
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= lrm_pkg::LRM_HOST_IDLE;
            count_reg <= '0;
            hostEventOut <= 1'b0;
            eventTaken <= 1'b0;
        end else begin
            eventTaken <= 1'b0;
            unique case (state_reg)
                lrm_pkg::LRM_HOST_IDLE: begin
                    if (eventReq) begin
                        state_reg <= lrm_pkg::LRM_HOST_HIGH;
                        count_reg <= '0;
                        hostEventOut <= 1'b1;
                        eventTaken <= 1'b1;
                    end
                end
                lrm_pkg::LRM_HOST_HIGH: begin
                    if (count_reg == HighLast) begin
                        state_reg <= lrm_pkg::LRM_HOST_LOW;
                        count_reg <= '0;
                        hostEventOut <= 1'b0;
                    end else begin
                        count_reg <= count_reg + 1'b1;
                    end
                end
                lrm_pkg::LRM_HOST_LOW: begin
                    if (count_reg == LowLast) begin
                        state_reg <= lrm_pkg::LRM_HOST_IDLE;
                        count_reg <= '0;
                    end else begin
                        count_reg <= count_reg + 1'b1;
                    end
                end
                default: begin
                    state_reg <= lrm_pkg::LRM_HOST_IDLE;
                    hostEventOut <= 1'b0;
                end
            endcase
        end
    end
endmodule : lrm_host_pulse

// >>> hw/local_reset_nmi_mux.sv
// Routing of shared local reset and interrupt requests to the cores
`timescale 1ns/1ps
`include "lrm_params.svh"
module local_reset_nmi_mux (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Shared pins from the board
    input wire logic reset_irq_strobe_n,
    input wire logic [`LRM_SEL_WIDTH-1:0] core_select,
    input wire logic core_local_reset_n,
    input wire logic coreIrqPin_n,
    // Watchdog requests, one per core
    input wire logic [`LRM_NUM_CORES-1:0] watchdogReset,
    input wire logic [`LRM_NUM_CORES-1:0] watchdogIrq,
    // Power/sleep controller local reset requests
    input wire logic [`LRM_NUM_CORES-1:0] power_sleep_ctrlReset,
    // Chip-level interrupt generation requests
    input wire logic [`LRM_NUM_CORES-1:0] chipIrqReq,
    // Host event requests from the cores
    input wire logic [`LRM_NUM_CORES-1:0] hostEventReq,
    // Outputs to the cores
    output logic [`LRM_NUM_CORES-1:0] coreResetOut_n,
    output logic [`LRM_NUM_CORES-1:0] coreIrqOut_n,
    // Host event pin and per-core acknowledges
    output logic host_event_out,
    output logic [`LRM_NUM_CORES-1:0] hostEventAck
);
    logic strobeSync_n;
    logic [`LRM_SEL_WIDTH-1:0] selSync;
    logic resetPinSync_n;
    logic irqPinSync_n;
    logic [`LRM_NUM_CORES-1:0] pinReset_reg;
    logic [`LRM_NUM_CORES-1:0] pinIrq_reg;
    logic [`LRM_NUM_CORES-1:0] targets;
    lrm_pkg::lrm_pin_action_t action;
    logic anyHostReq;
    logic hostTaken;
    logic hostOwner_reg;
    logic hostPulse;

    // Returns the cores a select code names; reserved codes name none
    function automatic logic [`LRM_NUM_CORES-1:0] decodeTargets(
        input logic [`LRM_SEL_WIDTH-1:0] sel
    );
        logic [`LRM_NUM_CORES-1:0] result;
        result = '0;
        if (sel[`LRM_SEL_ALL_BIT]) begin
            result = '1;
        end else if (sel == `LRM_SEL_CORE0) begin
            result = `LRM_NUM_CORES'(1);
        end else if (sel == `LRM_SEL_CORE1) begin
            result = `LRM_NUM_CORES'(2);
        end
        return result;
    endfunction : decodeTargets

    // Strobe idles high so nothing is decoded out of reset
    lrm_sync #(
        .WIDTH(1),
        .RESET_VALUE(1'b1)
    ) u_strobe_sync (
        .clk(clk),
        .reset(reset),
        .asyncIn(reset_irq_strobe_n),
        .syncOut(strobeSync_n)
    );

    lrm_sync #(
        .WIDTH(`LRM_SEL_WIDTH + 2),
        .RESET_VALUE({{`LRM_SEL_WIDTH{1'b0}}, 2'b11})
    ) u_pin_sync (
        .clk(clk),
        .reset(reset),
        .asyncIn({core_select, core_local_reset_n, coreIrqPin_n}),
        .syncOut({selSync, resetPinSync_n, irqPinSync_n})
    );

    // Which of the three table actions the shared pins ask for
    always_comb begin
        if (!resetPinSync_n) begin
            action = lrm_pkg::LRM_PIN_RESET;
        end else if (irqPinSync_n) begin
            action = lrm_pkg::LRM_PIN_RELEASE;
        end else begin
            action = lrm_pkg::LRM_PIN_IRQ;
        end
    end

    assign targets = decodeTargets(selSync);

    // Pin-driven local reset state per core; held while the strobe is high
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pinReset_reg <= '0;
        end else if (!strobeSync_n) begin
            unique case (action)
                lrm_pkg::LRM_PIN_RESET: pinReset_reg <= pinReset_reg | targets;
                lrm_pkg::LRM_PIN_RELEASE: pinReset_reg <= pinReset_reg & ~targets;
                lrm_pkg::LRM_PIN_IRQ: pinReset_reg <= pinReset_reg;
            endcase
        end
    end

    // Pin-driven interrupt state per core
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pinIrq_reg <= '0;
        end else if (!strobeSync_n) begin
            unique case (action)
                lrm_pkg::LRM_PIN_RESET: pinIrq_reg <= pinIrq_reg;
                lrm_pkg::LRM_PIN_RELEASE: pinIrq_reg <= pinIrq_reg & ~targets;
                lrm_pkg::LRM_PIN_IRQ: pinIrq_reg <= pinIrq_reg | targets;
            endcase
        end
    end

    // Merge pin, watchdog, power controller and chip register sources
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            coreResetOut_n <= '1;
            coreIrqOut_n <= '1;
        end else begin
            coreResetOut_n <= ~(pinReset_reg | watchdogReset | power_sleep_ctrlReset);
            coreIrqOut_n <= ~(pinIrq_reg | watchdogIrq | chipIrqReq);
        end
    end

    // Core 0 wins when both cores ask for a host event together
    assign anyHostReq = |hostEventReq;

    lrm_host_pulse u_host_pulse (
        .clk(clk),
        .reset(reset),
        .eventReq(anyHostReq),
        .hostEventOut(hostPulse),
        .eventTaken(hostTaken)
    );

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            host_event_out <= 1'b0;
            hostOwner_reg <= 1'b0;
            hostEventAck <= '0;
        end else begin
            host_event_out <= hostPulse;
            hostOwner_reg <= hostEventReq[0] ? 1'b0 : 1'b1;
            hostEventAck <= '0;
            if (hostTaken) begin
                hostEventAck <= hostOwner_reg ? `LRM_NUM_CORES'(2) : `LRM_NUM_CORES'(1);
            end
        end
    end
endmodule : local_reset_nmi_mux

// >>> tb/lrm_assertions.sv
// Port assertions of the routing block
`timescale 1ns/1ps
`include "lrm_params.svh"
module lrm_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Pins and direct sources
    input wire logic reset_irq_strobe_n,
    input wire logic [`LRM_SEL_WIDTH-1:0] core_select,
    input wire logic core_local_reset_n,
    input wire logic coreIrqPin_n,
    input wire logic [`LRM_NUM_CORES-1:0] watchdogReset,
    input wire logic [`LRM_NUM_CORES-1:0] watchdogIrq,
    input wire logic [`LRM_NUM_CORES-1:0] power_sleep_ctrlReset,
    input wire logic [`LRM_NUM_CORES-1:0] chipIrqReq,
    // Outputs
    input wire logic [`LRM_NUM_CORES-1:0] coreResetOut_n,
    input wire logic [`LRM_NUM_CORES-1:0] coreIrqOut_n,
    input wire logic host_event_out
);
    logic quiet;
    logic lastHost_reg;
    logic [5:0] runLen_reg;
    assign quiet = ~|{watchdogReset, watchdogIrq, power_sleep_ctrlReset, chipIrqReq};
    // Length of the host pin run that just ended
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lastHost_reg <= 1'b0;
            runLen_reg <= 6'h18;
        end else begin
            lastHost_reg <= host_event_out;
            if (host_event_out != lastHost_reg)
                runLen_reg <= 6'h01;
            else if (runLen_reg != 6'h3f)
                runLen_reg <= runLen_reg + 6'h01;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_wdRst; watchdogReset[0] |=> !coreResetOut_n[0]; endproperty
    a_wdRst: assert property (p_wdRst) else $error("wd reset");
    property p_chipIrq; chipIrqReq[1] |=> !coreIrqOut_n[1]; endproperty
    a_chipIrq: assert property (p_chipIrq) else $error("chip irq");
    property p_hostHigh; !host_event_out && lastHost_reg |-> runLen_reg == 6'h18; endproperty
    a_hostHigh: assert property (p_hostHigh) else $error("host high");
    property p_hostLow; host_event_out && !lastHost_reg |-> runLen_reg >= 6'h18; endproperty
    a_hostLow: assert property (p_hostLow) else $error("host low");
    property p_strobeIdle;
        (reset_irq_strobe_n && quiet)[*5] |=> $stable({coreResetOut_n, coreIrqOut_n});
    endproperty
    a_strobeIdle: assert property (p_strobeIdle) else $error("strobe idle");
    property p_resetAll;
        (!reset_irq_strobe_n && !core_local_reset_n && core_select[3])[*5]
            |=> coreResetOut_n == 2'h0;
    endproperty
    a_resetAll: assert property (p_resetAll) else $error("reset all");
    property p_irqCore1;
        (!reset_irq_strobe_n && core_local_reset_n && !coreIrqPin_n && core_select == 4'h1)[*5]
            |=> !coreIrqOut_n[1];
    endproperty
    a_irqCore1: assert property (p_irqCore1) else $error("irq core1");
    property p_rel0;
        (!reset_irq_strobe_n && core_local_reset_n && coreIrqPin_n && core_select == 4'h0
            && quiet)[*5] |=> coreResetOut_n[0] && coreIrqOut_n[0];
    endproperty
    a_rel0: assert property (p_rel0) else $error("release core0");
    property p_reserved;
        (!reset_irq_strobe_n && core_select inside {[4'h2:4'h7]} && quiet)[*5]
            |=> $stable({coreResetOut_n, coreIrqOut_n});
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved");
endmodule : lrm_assertions

// >>> tb/lrm_board_model.sv
// Board logic driving the shared decode pins
`timescale 1ns/1ps
module lrm_board_model (
    // Clock
    input wire logic clk,
    // Pins
    output logic strobe_n,
    output logic [3:0] sel,
    output logic rstPin_n,
    output logic irqPin_n
);
    initial {strobe_n, sel, rstPin_n, irqPin_n} = 7'h7f;
    task automatic decode(input logic [3:0] s, input logic r, input logic i);
        @(negedge clk);
        {sel, rstPin_n, irqPin_n} = {s, r, i};
        repeat (12) @(negedge clk);
        strobe_n = 1'b0;
        repeat (12) @(negedge clk);
        strobe_n = 1'b1;
        repeat (12) @(negedge clk);
        // Released pins no longer hold their value
        {sel, rstPin_n, irqPin_n} = ~{s, r, i};
    endtask : decode
endmodule : lrm_board_model

// >>> tb/tb.sv
// Self-checking testbench of the routing block
`timescale 1ns/1ps
`include "lrm_params.svh"
module tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic strobe_n, rstPin_n, irqPin_n, hostOut;
    logic [3:0] sel;
    logic [1:0] wdRst = 2'h0, wdIrq = 2'h0, pscRst = 2'h0, chipIrq = 2'h0, hostReq = 2'h0;
    logic [1:0] rstOut_n, irqOut_n, ack;
    logic [15:0] lfsr = 16'ha05e;
    int mismatches = 0, checks = 0, gap;
    int expRst[2] = '{1, 1}, expIrq[2] = '{1, 1};
    always #5 clk = ~clk;
    lrm_board_model board (.clk(clk), .strobe_n(strobe_n), .sel(sel), .rstPin_n(rstPin_n),
        .irqPin_n(irqPin_n));
    local_reset_nmi_mux dut (.clk(clk), .reset(reset), .reset_irq_strobe_n(strobe_n),
        .core_select(sel), .core_local_reset_n(rstPin_n), .coreIrqPin_n(irqPin_n),
        .watchdogReset(wdRst), .watchdogIrq(wdIrq), .power_sleep_ctrlReset(pscRst),
        .chipIrqReq(chipIrq), .hostEventReq(hostReq), .coreResetOut_n(rstOut_n),
        .coreIrqOut_n(irqOut_n), .host_event_out(hostOut), .hostEventAck(ack));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic apply(input logic [3:0] s, input logic r, input logic i);
        board.decode(s, r, i);
        repeat (8) @(negedge clk);
        for (int c = 0; c < 2; c++) begin
            if (s[3] || s == 4'(c)) begin
                if (!r)
                    expRst[c] = 0;
                else if (!i)
                    expIrq[c] = 0;
                else
                    {expRst[c], expIrq[c]} = {32'sd1, 32'sd1};
            end
        end
        check("reset", {6'h00, expRst[1][0], expRst[0][0]}, {6'h00, rstOut_n});
        check("irq", {6'h00, expIrq[1][0], expIrq[0][0]}, {6'h00, irqOut_n});
    endtask : apply
    task automatic hostEvent(input logic [1:0] req, input logic [1:0] expAck);
        int high;
        gap = 0;
        high = 0;
        hostReq = req;
        while (ack === 2'h0 && gap < 200) begin
            @(negedge clk);
            gap++;
        end
        check("host ack", {6'h00, expAck}, {6'h00, ack});
        hostReq = 2'h0;
        while (hostOut === 1'b1 && high < 200) begin
            @(negedge clk);
            high++;
        end
        check("host high", 8'(`LRM_HOST_HIGH_PERIODS), 8'(high));
    endtask : hostEvent
    initial begin
        logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h2, 4'h9, 4'h7, 4'hf};
        repeat (12) @(negedge clk);
        reset = 1'b0;
        foreach (codes[k]) begin
            apply(codes[k], 1'b1, 1'b1);
            apply(codes[k], 1'b1, 1'b0);
            apply(codes[k], 1'b0, 1'b0);
        end
        $display("decode test done");
        apply(4'h8, 1'b1, 1'b1);
        // Reserved codes after a release, so any change would show
        apply(4'h2, 1'b1, 1'b0);
        apply(4'h3, 1'b0, 1'b0);
        for (int n = 0; n < 40; n++) begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            {wdRst, wdIrq, pscRst, chipIrq} = lfsr[7:0];
            @(negedge clk);
            check("direct reset", {6'h00, ~(wdRst | pscRst)}, {6'h00, rstOut_n});
            check("direct irq", {6'h00, ~(wdIrq | chipIrq)}, {6'h00, irqOut_n});
        end
        {wdRst, wdIrq, pscRst, chipIrq} = 8'h00;
        $display("direct source test done");
        hostEvent(2'h3, 2'h1);
        hostEvent(2'h2, 2'h2);
        check("host low", 8'h01, {7'h00, gap >= `LRM_HOST_LOW_PERIODS});
        $display("host event test done");
        apply(4'h0, 1'b0, 1'b0);
        // Reset in mid-run clears the sticky pin state
        reset = 1'b1;
        @(negedge clk);
        check("reset state", 8'h0f, {3'h0, hostOut, rstOut_n, irqOut_n});
        reset = 1'b0;
        expRst = '{1, 1};
        expIrq = '{1, 1};
        repeat (2) @(negedge clk);
        check("state after reset", 8'h0f, {3'h0, hostOut, rstOut_n, irqOut_n});
        apply(4'h1, 1'b1, 1'b0);
        $display("reset test done");
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
endmodule : tb
bind local_reset_nmi_mux lrm_assertions chk (.clk, .reset, .reset_irq_strobe_n, .core_select,
    .core_local_reset_n, .coreIrqPin_n, .watchdogReset, .watchdogIrq, .power_sleep_ctrlReset,
    .chipIrqReq, .coreResetOut_n, .coreIrqOut_n, .host_event_out);
